// File: logic/puc_defs.svh
`ifndef PUC_DEFS_SVH
`define PUC_DEFS_SVH

// ----------------------------------------
// Register map
// ----------------------------------------
`define PUC_IDX_PORT 10'h0C2
`define PUC_IDX_UART 10'h0C3
`define PUC_IDX_STAT 10'h0FC
`define PUC_PORT_RST 32'h41111111
`define PUC_PORT_MASK 32'hCFFFFFFF
`define PUC_UART_RST 32'h10216600

// ----------------------------------------
// Field positions
// ----------------------------------------
`define PUC_SCK_LSB 30
`define PUC_PIN_STRIDE 4
`define PUC_POLY_LSB 16
`define PUC_ORDER_BIT 15
`define PUC_PRE_BIT 14
`define PUC_CMODE_BIT 13
`define PUC_WUP_BIT 12
`define PUC_HBR_LSB 10
`define PUC_HBM_BIT 9
`define PUC_ICLR_BIT 8
`define PUC_ADR_LSB 4
`define PUC_LEN_LSB 0
`define PUC_SPI_PINS 7'h0C

// ----------------------------------------
// Codes and values
// ----------------------------------------
`define PUC_DIR_OUT 2'h0
`define PUC_DIR_PU 2'h1
`define PUC_DIR_PD 2'h2
`define PUC_PRE_ZERO 16'h0000
`define PUC_PRE_ONES 16'h1111
`define PUC_DEF_POLY 16'h1021
`define PUC_DEF_ORDER 1'h0
`define PUC_DEF_PRE 16'h1111
`define PUC_BAUD0 17'h04B00
`define PUC_BAUD1 17'h09600
`define PUC_BAUD2 17'h0E100
`define PUC_BAUD3 17'h1C200

`endif

// File: logic/puc_pkg.sv
`default_nettype none
package puc_pkg;
  typedef struct packed {
    logic [15:0] poly;
    logic reversed;
    logic [15:0] preload;
  } puc_crc_cfg_t;

  typedef struct packed {
    logic [6:0] out;
    logic [6:0] oe;
    logic [6:0] pu;
    logic [6:0] pd;
  } puc_pins_t;
endpackage : puc_pkg
`default_nettype wire

// File: logic/puc_top.sv
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "puc_defs.svh"
module puc_top
  import puc_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic srst_in,
  // Register port
  input wire logic [11:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out,
  // Operating modes
  input wire logic spi_mode_in,
  input wire logic flow_meter_mode_in,
  input wire logic rc_crc_mode_in,
  // Internal output sources
  input wire logic [6:0] gp_out_bits_in,
  input wire logic pulse_in,
  input wire logic pulse_dir_in,
  input wire logic lsclk_in,
  input wire logic fire_burst_in,
  input wire logic err_n_in,
  input wire logic device_busy_in,
  input wire logic us_dir_in,
  input wire logic us_meas_busy_in,
  input wire logic us_fire_busy_in,
  input wire logic us_rx_busy_in,
  // Port pins
  input wire logic [6:0] pin_in,
  output puc_pins_t pins_out,
  input wire logic sck_rxd_pin_in,
  output logic sck_pu_out,
  output logic sck_pd_out,
  output logic sck_rxd_out,
  output logic slave_select_in_out,
  output logic mosi_out,
  // Serial interface settings
  output puc_crc_cfg_t crc_cfg_out,
  input wire logic wakeup_cmd_in,
  output logic wakeup_accept_out,
  input wire logic remote_high_rate_in,
  input wire logic auto_msg_active_in,
  output logic high_rate_active_out,
  output logic [16:0] high_rate_baud_out,
  output logic remote_irq_auto_clear_out,
  output logic [3:0] auto_msg_base_upper_out,
  output logic [3:0] auto_msg_length_out,
  output logic auto_msg_enable_out
);

  // ----------------------------------------
  // Registers and address decode
  // ----------------------------------------
  logic [31:0] port_q;
  logic [31:0] uart_q;
  logic [31:0] rdata_q;
  logic [6:0] pin_s1_q;
  logic [6:0] pin_s2_q;
  logic sck_s1_q;
  logic sck_s2_q;

  wire aligned = (addr_in[1:0] == 2'h0);
  wire sel_port = aligned && (addr_in[11:2] == `PUC_IDX_PORT);
  wire sel_uart = aligned && (addr_in[11:2] == `PUC_IDX_UART);
  wire sel_stat = aligned && (addr_in[11:2] == `PUC_IDX_STAT);
  wire [31:0] stat_word = {24'h000000, sck_s2_q, pin_s2_q};
  wire [31:0] rd_mux = sel_port ? port_q :
                       sel_uart ? uart_q :
                       sel_stat ? stat_word : 32'h00000000;

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      port_q <= `PUC_PORT_RST;
      uart_q <= `PUC_UART_RST;
    end else if (wr_in) begin
      if (sel_port) begin
        port_q <= wdata_in & `PUC_PORT_MASK;
      end
      // Polynomial stored as written; bit 16 is software's duty
      // polynomial write
      if (sel_uart) begin
        uart_q <= wdata_in;
      end
    end
  end

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      rdata_q <= 32'h00000000;
    end else begin
      rdata_q <= rd_in ? rd_mux : 32'h00000000;
    end
  end
  assign rdata_out = rdata_q;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      pin_s1_q <= 7'h00;
      pin_s2_q <= 7'h00;
      sck_s1_q <= 1'b0;
      sck_s2_q <= 1'b0;
    end else begin
      pin_s1_q <= pin_in;
      pin_s2_q <= pin_s1_q;
      sck_s1_q <= sck_rxd_pin_in;
      sck_s2_q <= sck_s1_q;
    end
  end

  // ----------------------------------------
  // Port output sources
  // ----------------------------------------
  logic [3:0] src [7];
  assign src[0] = {fire_burst_in, lsclk_in, pulse_in, gp_out_bits_in[0]};
  assign src[1] = {us_dir_in, err_n_in, pulse_dir_in, gp_out_bits_in[1]};
  assign src[2] = {lsclk_in, device_busy_in, pulse_in, gp_out_bits_in[2]};
  assign src[3] = {err_n_in, device_busy_in, pulse_dir_in, gp_out_bits_in[3]};
  assign src[4] = {us_fire_busy_in, device_busy_in, us_meas_busy_in,
                   gp_out_bits_in[4]};
  assign src[5] = {us_meas_busy_in, lsclk_in, pulse_in, gp_out_bits_in[5]};
  assign src[6] = {us_rx_busy_in, err_n_in, pulse_dir_in, gp_out_bits_in[6]};

  // ----------------------------------------
  // Direction decode per port
  // ----------------------------------------
  puc_pins_t pins_d;
  puc_pins_t pins_q;
  wire [6:0] spi_pins = spi_mode_in ? `PUC_SPI_PINS : 7'h00;

  genvar gi;
  generate
    for (gi = 0; gi < 7; gi++) begin : g_pin
      wire [1:0] dir = port_q[gi*`PUC_PIN_STRIDE +: 2];
      wire [1:0] sel = port_q[gi*`PUC_PIN_STRIDE+2 +: 2];
      wire spi_hiz = spi_pins[gi] && (dir == `PUC_DIR_OUT);
      wire drive = (dir == `PUC_DIR_OUT) && !spi_hiz;
      assign pins_d.oe[gi] = drive;
      assign pins_d.out[gi] = drive && src[gi][sel];
      assign pins_d.pu[gi] = (dir == `PUC_DIR_PU);
      assign pins_d.pd[gi] = (dir == `PUC_DIR_PD);
    end
  endgenerate

  wire [1:0] sck_cfg = port_q[`PUC_SCK_LSB +: 2];

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      pins_q <= '0;
      sck_pu_out <= 1'b0;
      sck_pd_out <= 1'b0;
    end else begin
      pins_q <= pins_d;
      sck_pu_out <= (sck_cfg == `PUC_DIR_PU);
      sck_pd_out <= (sck_cfg == `PUC_DIR_PD);
    end
  end
  assign pins_out = pins_q;

  // Slave select and MOSI idle inactive outside SPI mode; SCK/RXD follows the pin in every mode
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      sck_rxd_out <= 1'b0;
      slave_select_in_out <= 1'b1;
      mosi_out <= 1'b0;
    end else begin
      sck_rxd_out <= sck_s2_q;
      slave_select_in_out <= spi_mode_in ? pin_s2_q[2] : 1'b1;
      mosi_out <= spi_mode_in && pin_s2_q[3];
    end
  end

  // ----------------------------------------
  // Serial interface settings
  // ----------------------------------------
  // preload select
  wire [15:0] cfg_pre = uart_q[`PUC_PRE_BIT] ? `PUC_PRE_ONES : `PUC_PRE_ZERO;
  wire use_cfg = flow_meter_mode_in ? uart_q[`PUC_CMODE_BIT] : rc_crc_mode_in;
  puc_crc_cfg_t crc_d;
  assign crc_d.poly = use_cfg ? uart_q[`PUC_POLY_LSB +: 16] : `PUC_DEF_POLY;
  assign crc_d.reversed = use_cfg ? uart_q[`PUC_ORDER_BIT] : `PUC_DEF_ORDER;
  assign crc_d.preload = use_cfg ? cfg_pre : `PUC_DEF_PRE;

  wire [1:0] hbr = uart_q[`PUC_HBR_LSB +: 2];
  wire [16:0] baud_d = (hbr == 2'h0) ? `PUC_BAUD0 :
                       (hbr == 2'h1) ? `PUC_BAUD1 :
                       (hbr == 2'h2) ? `PUC_BAUD2 : `PUC_BAUD3;
  // auto message may also use high rate
  wire hr_d = remote_high_rate_in ||
              (uart_q[`PUC_HBM_BIT] && auto_msg_active_in);
  wire [3:0] len = uart_q[`PUC_LEN_LSB +: 4];

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      crc_cfg_out <= '0;
      wakeup_accept_out <= 1'b0;
      high_rate_active_out <= 1'b0;
      high_rate_baud_out <= 17'h00000;
      remote_irq_auto_clear_out <= 1'b0;
      auto_msg_base_upper_out <= 4'h0;
      auto_msg_length_out <= 4'h0;
      auto_msg_enable_out <= 1'b0;
    end else begin
      crc_cfg_out <= crc_d;
      wakeup_accept_out <= wakeup_cmd_in && uart_q[`PUC_WUP_BIT];
      high_rate_active_out <= hr_d;
      high_rate_baud_out <= baud_d;
      remote_irq_auto_clear_out <= uart_q[`PUC_ICLR_BIT];
      auto_msg_base_upper_out <= uart_q[`PUC_ADR_LSB +: 4];
      auto_msg_length_out <= len;
      auto_msg_enable_out <= (len != 4'h0);
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  sck_pull_a: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    wr_in && sel_port |-> ##2
      (sck_pu_out == ($past(wdata_in[31:30], 2) == 2'h1)) &&
      (sck_pd_out == ($past(wdata_in[31:30], 2) == 2'h2)))
    else $error("clock pin pull wrong after write");

  port0_dir_a: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    wr_in && sel_port |-> ##2
      (pins_out.oe[0] == ($past(wdata_in[1:0], 2) == 2'h0)))
    else $error("port 0 drive does not follow direction");

  port4_pull_a: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    (port_q[17:16] == 2'h2) |=> pins_out.pd[4] && !pins_out.pu[4] && !pins_out.oe[4])
    else $error("port 4 pull-down decode wrong");

  spi_ssel_a: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    spi_mode_in && (port_q[9:8] == 2'h0) |=>
      !pins_out.oe[2] && !pins_out.pu[2] && !pins_out.pd[2])
    else $error("port 2 driven in SPI mode");

  spi_mosi_a: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    spi_mode_in && (port_q[13:12] == 2'h0) |=> !pins_out.oe[3] && !pins_out.out[3])
    else $error("port 3 driven in SPI mode");

  port0_src_a: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    (port_q[3:0] == 4'h4) |=> pins_out.out[0] == $past(pulse_in))
    else $error("port 0 pulse source not routed");

  port4_src_a: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    (port_q[19:16] == 4'h8) |=> pins_out.out[4] == $past(device_busy_in))
    else $error("port 4 busy source not routed");

  input_nodrive_a: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    (port_q[25:24] != 2'h0) |=> !pins_out.oe[6] && !pins_out.out[6])
    else $error("port 6 driven while input");

  crc_pre_a: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    flow_meter_mode_in && uart_q[13] && !uart_q[14] |=>
      crc_cfg_out.preload == 16'h0000)
    else $error("crc preload not zero");

  crc_def_a: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    flow_meter_mode_in && !uart_q[13] |=>
      crc_cfg_out.poly == 16'h1021 && !crc_cfg_out.reversed)
    else $error("crc default settings not applied");

  wakeup_gate_a: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    wakeup_accept_out |-> $past(wakeup_cmd_in) && $past(uart_q[12]))
    else $error("wake-up accepted while disabled");

  baud_top_a: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    wr_in && sel_uart && (wdata_in[11:10] == 2'h3) |-> ##2
      high_rate_baud_out == 17'h1C200)
    else $error("high baud rate code 3 wrong");

  msg_len_a: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    auto_msg_enable_out == ($past(uart_q[3:0]) != 4'h0))
    else $error("auto message enable does not follow length");

  port1_src_a: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    (port_q[7:4] == 4'hC) |=> pins_out.out[1] == $past(us_dir_in))
    else $error("port 1 direction source not routed");

  port2_src_a: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    !spi_mode_in && (port_q[11:8] == 4'h8) |=> pins_out.out[2] == $past(device_busy_in))
    else $error("port 2 busy source not routed");

  port3_src_a: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    !spi_mode_in && (port_q[15:12] == 4'hC) |=> pins_out.out[3] == $past(err_n_in))
    else $error("port 3 error source not routed");

  port5_src_a: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    (port_q[23:20] == 4'h4) |=> pins_out.out[5] == $past(pulse_in))
    else $error("port 5 pulse source not routed");

  port6_src_a: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    (port_q[27:24] == 4'hC) |=> pins_out.out[6] == $past(us_rx_busy_in))
    else $error("port 6 receive busy source not routed");

  port1_float_a: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    (port_q[5:4] == 2'h3) |=> !pins_out.oe[1] && !pins_out.pu[1] && !pins_out.pd[1])
    else $error("port 1 floating input decode wrong");

  port0_pullup_a: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    (port_q[1:0] == 2'h1) |=> pins_out.pu[0] && !pins_out.pd[0] && !pins_out.oe[0])
    else $error("port 0 pull-up decode wrong");

  crc_poly_a: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    flow_meter_mode_in && uart_q[13] |=> crc_cfg_out.poly == $past(uart_q[31:16]))
    else $error("configured crc polynomial not applied");

  crc_order_a: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    flow_meter_mode_in && uart_q[13] |=> crc_cfg_out.reversed == $past(uart_q[15]))
    else $error("configured crc order not applied");

  crc_remote_a: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    !flow_meter_mode_in && rc_crc_mode_in |=> crc_cfg_out.poly == $past(uart_q[31:16]))
    else $error("remote crc mode copy not applied");

  wakeup_on_a: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    wakeup_cmd_in && uart_q[12] |=> wakeup_accept_out)
    else $error("enabled wake-up command ignored");

  high_rate_a: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    uart_q[9] && auto_msg_active_in |=> high_rate_active_out)
    else $error("auto message not at high rate");

  irq_clear_a: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    remote_irq_auto_clear_out == $past(uart_q[8]))
    else $error("interrupt clear policy wrong");

  msg_base_a: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    auto_msg_base_upper_out == $past(uart_q[7:4]))
    else $error("auto message base bits wrong");

endmodule : puc_top
`default_nettype wire

// File: tb/puc_pad_model.sv
`timescale 1ns/1ps
`default_nettype none
module puc_pad_model
  import puc_pkg::*;
(
  // Clock
  input wire logic ref_clk_in,
  // Pad controls from the block
  input wire puc_pins_t pins_in,
  input wire logic sck_pu_in,
  input wire logic sck_pd_in,
  // Resolved pad levels
  output logic [6:0] pin_out,
  output logic sck_out
);
  // ----------------------------------------
  // Board pads
  // ----------------------------------------
  // Undriven, unpulled pads wander so a stale level never reads as valid
  logic wander_q = 1'b0;

  always @(posedge ref_clk_in) begin
    wander_q <= ~wander_q;
  end

  always_comb begin
    for (int i = 0; i < 7; i++) begin
      if (pins_in.oe[i]) pin_out[i] = pins_in.out[i];
      else if (pins_in.pu[i]) pin_out[i] = 1'b1;
      else if (pins_in.pd[i]) pin_out[i] = 1'b0;
      else pin_out[i] = wander_q;
    end
    sck_out = sck_pu_in ? 1'b1 : (sck_pd_in ? 1'b0 : wander_q);
  end
endmodule : puc_pad_model
`default_nettype wire

// File: tb/port_and_uart_config_test.sv
`timescale 1ns/1ps
`default_nettype none
module port_and_uart_config_test
  import puc_pkg::*;
;
  logic ref_clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic [11:0] addr_in = 12'h000;
  logic [31:0] wdata_in = 32'h0;
  logic wr_in = 1'b0, rd_in = 1'b0, spi_mode_in = 1'b0;
  logic flow_meter_mode_in = 1'b0, rc_crc_mode_in = 1'b0, wakeup_cmd_in = 1'b0;
  logic remote_high_rate_in = 1'b0, auto_msg_active_in = 1'b0;
  logic [10:0] src = 11'h000;
  logic [31:0] rdata_out;
  puc_pins_t pins_out;
  puc_crc_cfg_t crc_cfg_out;
  logic sck_pu_out, sck_pd_out, sck_rxd_out, ss_out, mosi_out;
  logic wake_out, hr_out, iclr_out, men_out, sck_lvl;
  logic [6:0] pin_lvl;
  logic [16:0] baud_out;
  logic [3:0] base_out, len_out;
  logic [16:0] bt [4] = '{17'h04B00, 17'h09600, 17'h0E100, 17'h1C200};
  int fails = 0, num_checks = 0, cycles = 0;

  puc_top dut (.ref_clk_in(ref_clk_in), .srst_in(srst_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .spi_mode_in(spi_mode_in), .flow_meter_mode_in(flow_meter_mode_in),
    .rc_crc_mode_in(rc_crc_mode_in), .gp_out_bits_in({7{src[0]}}), .pulse_in(src[1]),
    .pulse_dir_in(src[2]), .lsclk_in(src[3]), .fire_burst_in(src[4]), .err_n_in(src[5]),
    .device_busy_in(src[6]), .us_dir_in(src[7]), .us_meas_busy_in(src[8]),
    .us_fire_busy_in(src[9]), .us_rx_busy_in(src[10]), .pin_in(pin_lvl),
    .pins_out(pins_out), .sck_rxd_pin_in(sck_lvl), .sck_pu_out(sck_pu_out),
    .sck_pd_out(sck_pd_out), .sck_rxd_out(sck_rxd_out), .slave_select_in_out(ss_out),
    .mosi_out(mosi_out), .crc_cfg_out(crc_cfg_out), .wakeup_cmd_in(wakeup_cmd_in),
    .wakeup_accept_out(wake_out), .remote_high_rate_in(remote_high_rate_in),
    .auto_msg_active_in(auto_msg_active_in), .high_rate_active_out(hr_out),
    .high_rate_baud_out(baud_out), .remote_irq_auto_clear_out(iclr_out),
    .auto_msg_base_upper_out(base_out), .auto_msg_length_out(len_out),
    .auto_msg_enable_out(men_out));

  puc_pad_model pads (.ref_clk_in(ref_clk_in), .pins_in(pins_out), .sck_pu_in(sck_pu_out),
    .sck_pd_in(sck_pd_out), .pin_out(pin_lvl), .sck_out(sck_lvl));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  initial begin
    forever #10 ref_clk_in = ~ref_clk_in;
  end

  task automatic give_verdict();
    if (fails == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : give_verdict

  // A hang costs at most this many cycles
  always @(posedge ref_clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fails = fails + 1;
      give_verdict();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic settle(input int n);
    repeat (n) @(posedge ref_clk_in);
    #1;
  endtask : settle

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge ref_clk_in);
    wr_in <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge ref_clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge ref_clk_in);
    rd_in <= 1'b0;
    #1;
    chk(rdata_out & m, e);
  endtask : rdc

  function automatic logic [6:0] exp_out(input int c, input logic [10:0] s);
    int tab [7][4];
    tab = '{'{0, 1, 3, 4}, '{0, 2, 5, 7}, '{0, 1, 6, 3}, '{0, 2, 6, 5}, '{0, 8, 6, 9},
      '{0, 1, 3, 8}, '{0, 2, 5, 10}};
    for (int n = 0; n < 7; n++) exp_out[n] = s[tab[n][c]];
  endfunction : exp_out

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [6:0] oe;
    logic [6:0] ev;
    logic [31:0] exp_w;
    logic cfg;
    repeat (20) @(posedge ref_clk_in);
    srst_in <= 1'b0;
    rdc(12'h308, 32'hFFFFFFFF, 32'h41111111);
    rdc(12'h30C, 32'hFFFFFFFF, 32'h10216600);
    rdc(12'h310, 32'hFFFFFFFF, 32'h00000000);
    for (int c = 0; c < 4; c++) begin
      wr(12'h308, {4'h4, {7{c[1:0], 2'b00}}});
      for (int i = 0; i < 11; i++) begin
        @(posedge ref_clk_in);
        src <= 11'h001 << i;
        settle(2);
        ev = exp_out(c, 11'h001 << i);
        chk(32'(pins_out.out), 32'(ev));
      end
    end
    @(posedge ref_clk_in);
    src <= 11'h001;
    for (int m = 0; m < 8; m++) begin
      @(posedge ref_clk_in);
      spi_mode_in <= m[2];
      wr(12'h308, {m[1:0], 2'b11, {7{2'b00, m[1:0]}}});
      settle(6);
      oe = (m[1:0] == 2'h0) ? (m[2] ? 7'h73 : 7'h7F) : 7'h00;
      exp_w = {4'h0, oe, oe, {7{m[1:0] == 2'h1}}, {7{m[1:0] == 2'h2}}};
      chk(32'(pins_out), exp_w);
      chk(32'({sck_pu_out, sck_pd_out}), 32'({m[1:0] == 2'h1, m[1:0] == 2'h2}));
      rdc(12'h308, 32'hFFFFFFFF, {m[1:0], 2'b00, {7{2'b00, m[1:0]}}});
      // Pulled levels only; floating pads wander
      if (m[1:0] == 2'h1 || m[1:0] == 2'h2) begin
        rdc(12'h3F0, 32'h000000FF, m[0] ? 32'h000000FF : 32'h00000000);
        chk(32'(sck_rxd_out), 32'(m[0]));
        chk(32'({ss_out, mosi_out}), 32'({m[2] ? m[0] : 1'b1, m[2] & m[0]}));
      end
    end
    @(posedge ref_clk_in);
    flow_meter_mode_in <= 1'b1;
    auto_msg_active_in <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      wr(12'h30C, {16'h8005, k[0], k[1], 1'b1, k[0], k[1:0], k[1], k[0], 4'(~(k * 5)),
        4'(k * 5)});
      settle(3);
      chk(32'(crc_cfg_out.poly), 32'h00008005);
      exp_w = {15'h0000, k[0], k[1] ? 16'h1111 : 16'h0000};
      chk(32'({crc_cfg_out.reversed, crc_cfg_out.preload}), exp_w);
      chk(32'(baud_out), 32'(bt[k]));
      chk(32'({hr_out, iclr_out}), 32'({k[1], k[0]}));
      exp_w = 32'({4'(~(k * 5)), 4'(k * 5), k != 0});
      chk(32'({base_out, len_out, men_out}), exp_w);
      @(posedge ref_clk_in);
      wakeup_cmd_in <= 1'b1;
      @(posedge ref_clk_in);
      wakeup_cmd_in <= 1'b0;
      #1;
      chk(32'(wake_out), 32'(k[0]));
      settle(1);
      chk(32'(wake_out), 32'h00000000);
    end
    wr(12'h30C, 32'h80058000);
    for (int j = 0; j < 4; j++) begin
      @(posedge ref_clk_in);
      flow_meter_mode_in <= j[1];
      rc_crc_mode_in <= j[0];
      remote_high_rate_in <= j[0];
      settle(3);
      cfg = !j[1] && j[0];
      chk(32'(crc_cfg_out.poly), cfg ? 32'h00008005 : 32'h00001021);
      exp_w = cfg ? 32'h00010000 : 32'h00001111;
      chk(32'({crc_cfg_out.reversed, crc_cfg_out.preload}), exp_w);
      chk(32'(hr_out), 32'(j[0]));
    end
    give_verdict();
  end
endmodule : port_and_uart_config_test
`default_nettype wire
